// >>> verilog/rcc_consts.svh
// offsets, field positions, reset values and timing for the channel config registers
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

`define RCC_OFS_A_DEEMPH     8'h11
`define RCC_OFS_A_IDLE       8'h12
`define RCC_OFS_SPARE_A      8'h13
`define RCC_OFS_B_SPARE      8'h14
`define RCC_OFS_B_DETECT     8'h15
`define RCC_OFS_B_EQ         8'h16

`define RCC_RST_A_DEEMPH     8'h82
`define RCC_RST_A_IDLE       8'h00
`define RCC_RST_SPARE        8'h00
`define RCC_RST_B_DETECT     8'h00
`define RCC_RST_B_EQ         8'h2f

`define RCC_RATE_HI          6
`define RCC_RATE_LO          5
`define RCC_DEEMPH_HI        2
`define RCC_DEEMPH_LO        0
`define RCC_DEEMPH_WR_MASK   8'h1f
`define RCC_A_DEEMPH_FIXED   8'h80
`define RCC_IDLE_ASSERT_HI   3
`define RCC_IDLE_ASSERT_LO   2
`define RCC_IDLE_DEASSERT_HI 1
`define RCC_IDLE_DEASSERT_LO 0
`define RCC_DETECT_HI        3
`define RCC_DETECT_LO        2
`define RCC_IDLE_DEFAULT     2'h0

`define RCC_CLK_HZ           10000000
`define RCC_TRY_PERIOD_MS    12
`define RCC_TRY_PERIOD_CYC   ((`RCC_CLK_HZ / 1000) * `RCC_TRY_PERIOD_MS)
`define RCC_TRY_LIMIT        50

`endif

// >>> verilog/rcc_pkg.sv
// types shared by the channel config register bank
package rcc_pkg;

	typedef enum logic [1:0]
	{
		DET_HIGH_Z,
		DET_AUTO_LIMITED,
		DET_AUTO_UNLIMITED,
		DET_FIXED_50
	} rcc_det_mode_e;

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SEARCH,
		ST_FOUND,
		ST_GAVE_UP
	} rcc_det_state_e;

	typedef logic [7:0] rcc_byte_t;

endpackage

// >>> verilog/rcc_regs.sv
// channel a / channel b configuration registers with far-end detect sequencer
// How it works
// - rate detected reads back at bits 6:5
// - de-emphasis code bits 2:0, default 010
// - idle assert level bits 3:2, default 00
// - idle deassert level bits 1:0, default 00
// - idle levels apply only when global enable
// - mode 00 high-z, mode 11 fixed 50 ohm
// - mode 01 tries every 12 ms, 50 times
// - mode 10 tries every 12 ms forever
// - auto modes high-z until detected, then 50
// - register mode overrides the pin mode
// - eight-bit equalizer level, default 0x2f
`timescale 1ns/1ps
`include "rcc_consts.svh"

module rcc_regs
	import rcc_pkg::*;
#(
	parameter int unsigned TRY_PERIOD_CYC = `RCC_TRY_PERIOD_CYC
)
(
	// clock, reset, enable
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// register access from the management bus engine
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// global control bit, kept in the global register elsewhere
	input  wire logic       idle_thresh_enable,
	// channel a
	input  wire logic [1:0] rate_detected_a,
	output logic      [2:0] tx_deemph_level_a,
	output logic      [1:0] idle_assert_level_a,
	output logic      [1:0] idle_deassert_level_a,
	// channel b
	input  wire logic [1:0] far_end_detect_mode_pin_b,
	input  wire logic       far_end_present_b,
	output logic            detect_try_b,
	output logic            term_50_b,
	output logic      [7:0] eq_level_b
);

	rcc_byte_t      a_deemph_q;
	rcc_byte_t      a_idle_q;
	rcc_byte_t      spare_a_q;
	rcc_byte_t      b_spare_q;
	rcc_byte_t      b_detect_q;
	rcc_byte_t      b_eq_q;
	logic           mode_written_q;
	rcc_det_state_e det_state_q;
	rcc_det_state_e det_state_d;
	rcc_det_mode_e  mode_prev_q;
	logic [31:0]    tick_q;
	logic [5:0]     tries_q;
	logic [7:0]     rdata_q;
	logic           rvalid_q;
	logic           term_q;
	logic [2:0]     deemph_out_q;
	logic [1:0]     assert_out_q;
	logic [1:0]     deassert_out_q;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	wire logic wr_a_deemph = reg_wr && hit(reg_addr, `RCC_OFS_A_DEEMPH);
	wire logic wr_a_idle   = reg_wr && hit(reg_addr, `RCC_OFS_A_IDLE);
	wire logic wr_spare_a  = reg_wr && hit(reg_addr, `RCC_OFS_SPARE_A);
	wire logic wr_b_spare  = reg_wr && hit(reg_addr, `RCC_OFS_B_SPARE);
	wire logic wr_b_detect = reg_wr && hit(reg_addr, `RCC_OFS_B_DETECT);
	wire logic wr_b_eq     = reg_wr && hit(reg_addr, `RCC_OFS_B_EQ);

	wire rcc_byte_t a_deemph_view = `RCC_A_DEEMPH_FIXED
		| {1'b0, rate_detected_a, a_deemph_q[4:0]};

	// unmapped offsets read as zero
	wire rcc_byte_t rd_mux =
		hit(reg_addr, `RCC_OFS_A_DEEMPH) ? a_deemph_view :
		hit(reg_addr, `RCC_OFS_A_IDLE)   ? a_idle_q :
		hit(reg_addr, `RCC_OFS_SPARE_A)  ? spare_a_q :
		hit(reg_addr, `RCC_OFS_B_SPARE)  ? b_spare_q :
		hit(reg_addr, `RCC_OFS_B_DETECT) ? b_detect_q :
		hit(reg_addr, `RCC_OFS_B_EQ)     ? b_eq_q : 8'h00;

	wire rcc_det_mode_e mode_eff = rcc_det_mode_e'(mode_written_q
		? b_detect_q[`RCC_DETECT_HI:`RCC_DETECT_LO] : far_end_detect_mode_pin_b);
	wire logic mode_changed = (mode_eff != mode_prev_q);
	wire logic auto_mode    = (mode_eff == DET_AUTO_LIMITED)
		|| (mode_eff == DET_AUTO_UNLIMITED);
	wire logic tick_done    = (tick_q == TRY_PERIOD_CYC - 1);
	wire logic try_now      = clk_en && !mode_changed
		&& (det_state_q == ST_SEARCH) && tick_done;

	// try budget reached on this attempt
	wire logic last_try = (mode_eff == DET_AUTO_LIMITED)
		&& (tries_q == 6'(`RCC_TRY_LIMIT - 1));

	always_comb
	begin
		det_state_d = det_state_q;
		if (mode_changed)
			det_state_d = auto_mode ? ST_SEARCH : ST_IDLE;
		else if (try_now)
		begin
			// switch to 50 ohm on success
			if (far_end_present_b)
				det_state_d = ST_FOUND;
			// give up after the last try
			else if (last_try)
				det_state_d = ST_GAVE_UP;
			else
				det_state_d = ST_SEARCH;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_deemph_q     <= `RCC_RST_A_DEEMPH;
			a_idle_q       <= `RCC_RST_A_IDLE;
			spare_a_q      <= `RCC_RST_SPARE;
			b_spare_q      <= `RCC_RST_SPARE;
			b_detect_q     <= `RCC_RST_B_DETECT;
			b_eq_q         <= `RCC_RST_B_EQ;
			mode_written_q <= 1'b0;
		end
		else if (clk_en)
		begin
			// de-emphasis field, rate bits stay read-only
			if (wr_a_deemph)
				a_deemph_q <= reg_wdata & `RCC_DEEMPH_WR_MASK;
			if (wr_a_idle)
				a_idle_q <= reg_wdata;
			if (wr_spare_a)
				spare_a_q <= reg_wdata;
			if (wr_b_spare)
				b_spare_q <= reg_wdata;
			if (wr_b_detect)
			begin
				b_detect_q     <= reg_wdata;
				mode_written_q <= 1'b1;
			end
			if (wr_b_eq)
				b_eq_q <= reg_wdata;
		end
	end

	// detection sequencer; a mode change restarts the count and the try budget
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			det_state_q <= ST_IDLE;
			mode_prev_q <= DET_HIGH_Z;
			tick_q      <= 32'h0;
			tries_q     <= 6'h0;
		end
		else if (clk_en)
		begin
			det_state_q <= det_state_d;
			mode_prev_q <= mode_eff;
			if (mode_changed || det_state_q != ST_SEARCH || tick_done)
				tick_q <= 32'h0;
			else
				tick_q <= tick_q + 32'h1;
			if (mode_changed)
				tries_q <= 6'h0;
			else if (try_now)
				tries_q <= tries_q + 6'h1;
		end
	end

	// outputs from flip-flops; read valid pulses one cycle after the strobe, read data holds until the next read
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q        <= 8'h00;
			rvalid_q       <= 1'b0;
			term_q         <= 1'b0;
			deemph_out_q   <= 3'h0;
			assert_out_q   <= `RCC_IDLE_DEFAULT;
			deassert_out_q <= `RCC_IDLE_DEFAULT;
		end
		else if (clk_en)
		begin
			rvalid_q <= reg_rd;
			if (reg_rd)
				rdata_q <= rd_mux;
			// fixed modes; auto modes follow detection
			term_q <= (mode_eff == DET_FIXED_50)
				|| (auto_mode && det_state_d == ST_FOUND);
			// channel a fields drive channel a only
			deemph_out_q <= a_deemph_q[`RCC_DEEMPH_HI:`RCC_DEEMPH_LO];
			// thresholds only under the global enable
			assert_out_q <= idle_thresh_enable
				? a_idle_q[`RCC_IDLE_ASSERT_HI:`RCC_IDLE_ASSERT_LO] : `RCC_IDLE_DEFAULT;
			deassert_out_q <= idle_thresh_enable
				? a_idle_q[`RCC_IDLE_DEASSERT_HI:`RCC_IDLE_DEASSERT_LO]
				: `RCC_IDLE_DEFAULT;
		end
	end

	assign reg_rdata             = rdata_q;
	assign reg_rvalid            = rvalid_q;
	assign tx_deemph_level_a     = deemph_out_q;
	assign idle_assert_level_a   = assert_out_q;
	assign idle_deassert_level_a = deassert_out_q;
	assign detect_try_b          = try_now;
	assign term_50_b             = term_q;
	assign eq_level_b            = b_eq_q;

endmodule

// >>> bench/rcc_regs_asserts.sv
// concurrent checks on the channel config register bank ports
`timescale 1ns/1ps
module rcc_regs_asserts
#(
	parameter int unsigned TRY_PERIOD_CYC = 8
)
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       idle_thresh_enable,
	input wire logic [1:0] rate_detected_a,
	input wire logic [2:0] tx_deemph_level_a,
	input wire logic [1:0] idle_assert_level_a,
	input wire logic [1:0] idle_deassert_level_a,
	input wire logic [1:0] far_end_detect_mode_pin_b,
	input wire logic       far_end_present_b,
	input wire logic       detect_try_b,
	input wire logic       term_50_b,
	input wire logic [7:0] eq_level_b
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire w11 = clk_en && reg_wr && reg_addr == 8'h11;
	wire w12 = clk_en && reg_wr && reg_addr == 8'h12;
	wire w16 = clk_en && reg_wr && reg_addr == 8'h16;
	a_rate_read: assert property (clk_en && reg_rd && reg_addr == 8'h11 |=> reg_rvalid
		&& reg_rdata[7] && reg_rdata[6:5] == $past(rate_detected_a)) else $error("rate read");
	a_deemph_write: assert property (w11 ##1 clk_en |=>
		tx_deemph_level_a == $past(reg_wdata[2:0], 2)) else $error("deemph write");
	a_idle_follow: assert property (w12 ##1 (clk_en && idle_thresh_enable) |=>
		{idle_assert_level_a, idle_deassert_level_a} == $past(reg_wdata[3:0], 2))
		else $error("idle levels");
	a_idle_gate: assert property (clk_en && !idle_thresh_enable |=>
		idle_assert_level_a == 2'h0 && idle_deassert_level_a == 2'h0) else $error("idle gate");
	a_try_term: assert property (detect_try_b && far_end_present_b |=> term_50_b)
		else $error("term after hit");
	a_try_spacing: assert property (detect_try_b |=> !detect_try_b [*7])
		else $error("try spacing");
	a_eq_write: assert property (w16 |=> eq_level_b == $past(reg_wdata))
		else $error("eq write");
	a_eq_hold: assert property (!w16 |=> $stable(eq_level_b))
		else $error("eq hold");
	// cycles since the last try, saturating, frozen with the enable
	logic [31:0] gap_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			gap_q <= 32'hffff_ffff;
		else if (clk_en && detect_try_b)
			gap_q <= 32'h0;
		else if (clk_en && gap_q != 32'hffff_ffff)
			gap_q <= gap_q + 32'h1;
	end
	a_try_gap: assert property (detect_try_b |-> gap_q >= TRY_PERIOD_CYC - 1)
		else $error("try gap");
	c_hit: cover property (detect_try_b && far_end_present_b);
	c_mode: cover property (clk_en && reg_wr && reg_addr == 8'h15);
	c_read: cover property (reg_rvalid);
endmodule
bind rcc_regs rcc_regs_asserts #(.TRY_PERIOD_CYC(TRY_PERIOD_CYC)) rcc_regs_asserts_inst (.*);

// >>> bench/rcc_far_end.sv
// far-end receiver model, seen present once enough tries went by
`timescale 1ns/1ps
module rcc_far_end
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// detection link
	input  wire logic       detect_try_b,
	input  wire logic [7:0] need,
	output logic            far_end_present_b
);
	logic [7:0] seen_q;
	logic [7:0] need_q;
	assign far_end_present_b = seen_q >= need;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n) {seen_q, need_q} <= 16'h0;
		else if (need != need_q) {seen_q, need_q} <= {8'h0, need};
		else if (detect_try_b) seen_q <= seen_q + 8'h1;
	end
endmodule

// >>> bench/test_repeater_channel_config_regs.sv
// self-checking bench for the channel config register bank
`timescale 1ns/1ps
module test_repeater_channel_config_regs;
	logic       sys_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic       idle_thresh_enable = 0, reg_rvalid, far_end_present_b, detect_try_b, term_50_b;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, eq_level_b, need = 8'hff, s, v;
	logic [1:0] rate_detected_a = 0, far_end_detect_mode_pin_b = 0, r;
	logic [1:0] idle_assert_level_a, idle_deassert_level_a;
	logic [2:0] tx_deemph_level_a;
	logic [31:0] seed = 16246;
	int         n_fail = 0, checked = 0, tries = 0;
	rcc_regs #(.TRY_PERIOD_CYC(8)) rcc_regs_inst (.*);
	rcc_far_end rcc_far_end_inst (.*);
	always #50 sys_clk = ~sys_clk;
	// try pulse is combinational, so count it away from the launching edge
	always @(negedge sys_clk) if (detect_try_b) tries++;
	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function logic [7:0] e11(logic [7:0] w, logic [1:0] rt);
		return 8'h80 | {1'b0, rt, 5'h0} | (w & 8'h1f);
	endfunction
	task chk(string nm, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task rd(logic [7:0] a, logic [7:0] exp);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
		chk("rdata", reg_rdata, exp);
	endtask
	task close_out();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1;
		rd(8'h11, 8'h82);
		for (int i = 2; i < 7; i++) rd(8'(8'h10 + i), i == 6 ? 8'h2f : 8'h00);
		rd(8'h17, 8'h00);
		chk("deemph", {5'h0, tx_deemph_level_a}, 8'h02);
		chk("term", {7'h0, term_50_b}, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			s = i == 0 ? 8'hff : rnd();
			v = i == 0 ? 8'hff : rnd();
			r = v[1:0] == 2'b10 ? 2'b11 : v[1:0];
			@(posedge sys_clk);
			{rate_detected_a, idle_thresh_enable} <= {r, v[2]};
			// reserved bits kept zero by software
			wr(8'h11, s & 8'h07);
			wr(8'h12, s & 8'h0f);
			wr(8'h16, v);
			rd(8'h11, e11(s & 8'h07, r));
			rd(8'h12, s & 8'h0f);
			rd(8'h16, v);
			chk("deemph", {5'h0, tx_deemph_level_a}, {5'h0, s[2:0]});
			chk("idle", {4'h0, idle_assert_level_a, idle_deassert_level_a},
				v[2] ? s & 8'h0f : 8'h00);
			chk("eq", eq_level_b, v);
		end
		// a write while the enable is low must be dropped
		@(posedge sys_clk);
		clk_en <= 0;
		wr(8'h16, ~v);
		clk_en <= 1;
		chk("eq frozen", eq_level_b, v);
		rd(8'h16, v);
		$display("register test done");
		@(posedge sys_clk);
		far_end_detect_mode_pin_b <= 2'b11;
		repeat (3) @(posedge sys_clk);
		chk("term pin", {7'h0, term_50_b}, 8'h01);
		wr(8'h15, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk("term reg", {7'h0, term_50_b}, 8'h00);
		need <= 8'd200;
		wr(8'h15, 8'h04);
		tries = 0;
		repeat (600) @(posedge sys_clk);
		chk("tries 01", tries[7:0], 8'd50);
		chk("term 01", {7'h0, term_50_b}, 8'h00);
		need <= 8'd60;
		wr(8'h15, 8'h08);
		tries = 0;
		repeat (700) @(posedge sys_clk);
		chk("tries 10", tries[7:0], 8'd61);
		chk("term 10", {7'h0, term_50_b}, 8'h01);
		$display("detect test done");
		close_out();
	end
	// about thirteen times the expected run
	initial
	begin
		#2000000;
		n_fail++;
		close_out();
	end
endmodule
